// ==== design/pfs_pad_function_select.sv ====
`timescale 1ns/100ps
module pfs_pad_function_select #(
   parameter logic [pfs_pkg::NUM_PADS*pfs_pkg::SEL_W-1:0] REL_MODES =
      {pfs_pkg::NUM_PADS{pfs_pkg::MODE_REL_DFLT}},
   parameter logic [pfs_pkg::NUM_PADS*3-1:0] RST_STATES =
      {pfs_pkg::NUM_PADS{pfs_pkg::PAD_RST_STATE}},
   parameter logic [pfs_pkg::NUM_PERIN*2-1:0] DESEL_VALS =
      {pfs_pkg::NUM_PERIN{pfs_pkg::DESEL_DFLT}},
   parameter int MCU_STRAP_W  = 4,
   parameter int MAIN_STRAP_W = 4
) (
   // Clock and resets
   input  wire logic                                   i_ref_clk,
   input  wire logic                                   i_rst,
   input  wire logic                                   i_mcu_poweron_reset_out,
   input  wire logic                                   i_main_poweron_reset_out,
   input  wire logic                                   i_reset_release,
   // Software configuration
   input  wire logic [pfs_pkg::NUM_PADS-1:0]           i_cfg_wr,
   input  wire pfs_pkg::pfs_pad_setup_t                i_cfg_wdata,
   output pfs_pkg::pfs_pad_setup_t [pfs_pkg::NUM_PADS-1:0] o_pad_setup_register,
   // Input routing, one pin_select_register per peripheral input
   input  wire logic [pfs_pkg::NUM_PERIN*pfs_pkg::PIN_W-1:0] i_pin_select_register,
   // Peripheral function ports, indexed pad*8+func
   input  wire logic [pfs_pkg::NUM_PADS*pfs_pkg::NUM_FUNCS-1:0] i_func_out,
   input  wire logic [pfs_pkg::NUM_PADS*pfs_pkg::NUM_FUNCS-1:0] i_func_oe,
   output logic      [pfs_pkg::NUM_PERIN-1:0]          o_periph_in,
   // Pads
   input  wire logic [pfs_pkg::NUM_PADS-1:0]           i_pad_in,
   output pfs_pkg::pfs_pad_drive_t [pfs_pkg::NUM_PADS-1:0] o_pad_drive,
   // Boot straps, taken from fixed pads
   output logic      [MCU_STRAP_W-1:0]                 o_mcu_boot_straps,
   output logic      [MAIN_STRAP_W-1:0]                o_main_boot_straps
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   localparam int SYW = pfs_pkg::NUM_PADS + 3;
   logic [SYW-1:0] sy1_reg;
   logic [SYW-1:0] sy2_reg;
   logic [SYW-1:0] sy3_reg;
   logic [SYW-1:0] stable_reg;
   wire  [SYW-1:0] sy_raw = {i_reset_release, i_main_poweron_reset_out,
                             i_mcu_poweron_reset_out, i_pad_in};
   // A change counts only once flops two and three agree,
   // so a one-cycle glitch on a pin never reaches the filtered level
   wire  [SYW-1:0] agree  = ~(sy2_reg ^ sy3_reg);
   wire  [SYW-1:0] stable_next = (agree & sy3_reg) | (~agree & stable_reg);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sy1_reg    <= '0;
         sy2_reg    <= '0;
         sy3_reg    <= '0;
         stable_reg <= '0;
      end else begin
         sy1_reg    <= sy_raw;
         sy2_reg    <= sy1_reg;
         sy3_reg    <= sy2_reg;
         stable_reg <= stable_next;
      end
   end

   wire [pfs_pkg::NUM_PADS-1:0] pad_lvl = stable_reg[pfs_pkg::NUM_PADS-1:0];
   wire mcu_por  = stable_reg[pfs_pkg::NUM_PADS];
   wire main_por = stable_reg[pfs_pkg::NUM_PADS+1];
   wire rel      = stable_reg[pfs_pkg::NUM_PADS+2];

   // ************************************************************
   // Edge detection and strap capture
   // ************************************************************
   logic mcu_por_d_reg;
   logic main_por_d_reg;
   logic rel_d_reg;
   wire  mcu_rise  = mcu_por & ~mcu_por_d_reg;
   wire  main_rise = main_por & ~main_por_d_reg;
   wire  rel_fall  = ~rel & rel_d_reg;

   // Delay flops reset to the filtered level, so no false edge follows reset
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         mcu_por_d_reg  <= 1'b0;
         main_por_d_reg <= 1'b0;
         rel_d_reg      <= 1'b0;
      end else begin
         mcu_por_d_reg  <= mcu_por;
         main_por_d_reg <= main_por;
         rel_d_reg      <= rel;
      end
   end

   // Straps share the low pads; captured in clocked logic, never at reset
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mcu_boot_straps  <= '0;
         o_main_boot_straps <= '0;
      end else begin
         if (mcu_rise) begin
            o_mcu_boot_straps <= pad_lvl[MCU_STRAP_W-1:0];
         end
         if (main_rise) begin
            o_main_boot_straps <= pad_lvl[MAIN_STRAP_W-1:0];
         end
      end
   end

   // ************************************************************
   // Power-on reset state
   // ************************************************************
   // Held in power-on reset while either reset output is low
   wire in_por = ~mcu_por | ~main_por;

   // ************************************************************
   // Pad setup registers and pad drive
   // ************************************************************
   genvar p;
   generate
      for (p = 0; p < pfs_pkg::NUM_PADS; p++) begin : g_pad
         pfs_pkg::pfs_pad_setup_t setup_reg;
         pfs_pkg::pfs_pad_drive_t drv_next;
         wire [2:0] rst_st = RST_STATES[p*3 +: 3];
         // Unused function slots carry whatever the peripheral side ties off
         wire [pfs_pkg::SEL_W-1:0] sel = setup_reg.func_sel;
         wire fo  = i_func_out[p*pfs_pkg::NUM_FUNCS + int'(sel)];
         wire foe = i_func_oe[p*pfs_pkg::NUM_FUNCS + int'(sel)];
         wire run_drv = ~setup_reg.driver_off & foe;

         // Fixed reset state, decoded once per pad; spare codes float
         wire rst_out  = (rst_st == pfs_pkg::RST_DRIVE1);
         wire rst_drv  = (rst_st == pfs_pkg::RST_DRIVE0) |
                         (rst_st == pfs_pkg::RST_DRIVE1);
         wire rst_pull = (rst_st == pfs_pkg::RST_FLOAT_PD) |
                         (rst_st == pfs_pkg::RST_FLOAT_PU);
         wire rst_up   = (rst_st == pfs_pkg::RST_FLOAT_PU);

         // Receiver off in power-on reset; straps use the synchronised, filtered pad level
         always_comb begin
            if (in_por) begin
               drv_next.out     = rst_out;
               drv_next.oe_n    = ~rst_drv;
               drv_next.rx_en   = 1'b0;
               drv_next.pull_en = rst_pull;
               drv_next.pull_up = rst_up;
            end else begin
               drv_next.out     = fo;
               drv_next.oe_n    = ~run_drv;
               drv_next.rx_en   = setup_reg.receiver_on;
               drv_next.pull_en = setup_reg.pull_en;
               drv_next.pull_up = setup_reg.pull_up;
            end
         end

         // A default-mode load beats a software write in the same cycle
         always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
               setup_reg.receiver_on <= pfs_pkg::RX_ON_RST;
               setup_reg.driver_off  <= pfs_pkg::DRV_OFF_RST;
               setup_reg.pull_en     <= pfs_pkg::PULL_EN_RST;
               setup_reg.pull_up     <= pfs_pkg::PULL_UP_RST;
               setup_reg.func_sel    <= pfs_pkg::MODE_PRIMARY;
               o_pad_drive[p]        <= '{out: 1'b0, oe_n: 1'b1, rx_en: 1'b0,
                                          pull_en: 1'b0, pull_up: 1'b0};
            end else begin
               if (rel_fall) begin
                  setup_reg.func_sel <= REL_MODES[p*pfs_pkg::SEL_W +: pfs_pkg::SEL_W];
               end else if (i_cfg_wr[p]) begin
                  setup_reg <= i_cfg_wdata;
               end
               o_pad_drive[p] <= drv_next;
            end
         end
         assign o_pad_setup_register[p] = setup_reg;
      end
   endgenerate

   // ************************************************************
   // Peripheral input routing
   // ************************************************************
   genvar q;
   generate
      for (q = 0; q < pfs_pkg::NUM_PERIN; q++) begin : g_in
         wire [pfs_pkg::PIN_W-1:0] psel =
            i_pin_select_register[q*pfs_pkg::PIN_W +: pfs_pkg::PIN_W];
         // Out-of-range select counts as unrouted; doubles are software's fault
         wire routed = (psel < pfs_pkg::PIN_W'(pfs_pkg::NUM_PADS));
         wire [2:0] pidx = psel[2:0];
         // Receiver gating: a routed input reads 0 while its pad receiver is off
         wire rx_ok  = o_pad_setup_register[pidx].receiver_on & ~in_por;
         wire [1:0] dv = DESEL_VALS[q*2 +: 2];
         // Input q has pad q as its home pad; needs as many pads as inputs
         wire desel_one = (dv == pfs_pkg::DESEL_ONE);
         wire desel_pad = (dv == pfs_pkg::DESEL_PAD);
         wire dsel = desel_one | (desel_pad & pad_lvl[q]);
         wire in_next = routed ? (rx_ok & pad_lvl[pidx]) : dsel;

         // Registered, so a select change never glitches a peripheral input
         always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
               o_periph_in[q] <= 1'b0;
            end else begin
               o_periph_in[q] <= in_next;
            end
         end
      end
   endgenerate

endmodule : pfs_pad_function_select

// ==== design/pfs_pkg.sv ====
package pfs_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int NUM_PADS  = 8;
   localparam int NUM_FUNCS = 8;
   localparam int NUM_PERIN = 8;
   localparam int SEL_W     = 3;
   localparam int PIN_W     = 4;

   // ************************************************************
   // Encodings
   // ************************************************************
   localparam logic [SEL_W-1:0] MODE_PRIMARY   = 3'h0;
   localparam logic [SEL_W-1:0] MODE_REL_DFLT  = 3'h7;
   localparam logic [1:0]       DESEL_ZERO     = 2'h0;
   localparam logic [1:0]       DESEL_ONE      = 2'h1;
   localparam logic [1:0]       DESEL_PAD      = 2'h2;
   localparam logic [2:0]       RST_DRIVE0     = 3'h0;
   localparam logic [2:0]       RST_DRIVE1     = 3'h1;
   localparam logic [2:0]       RST_FLOAT      = 3'h2;
   localparam logic [2:0]       RST_FLOAT_PD   = 3'h3;
   localparam logic [2:0]       RST_FLOAT_PU   = 3'h4;
   localparam logic [PIN_W-1:0] PIN_NONE       = 4'hF;

   // ************************************************************
   // Reset values of one pad setup register, default pad reset state and deselect value
   // ************************************************************
   localparam logic             RX_ON_RST      = 1'h1;
   localparam logic             DRV_OFF_RST    = 1'h1;
   localparam logic             PULL_EN_RST    = 1'h0;
   localparam logic             PULL_UP_RST    = 1'h0;
   localparam logic [2:0]       PAD_RST_STATE  = 3'h2;
   localparam logic [1:0]       DESEL_DFLT     = 2'h0;

   // Pad setup register fields
   typedef struct packed {
      logic             receiver_on;
      logic             driver_off;
      logic             pull_en;
      logic             pull_up;
      logic [SEL_W-1:0] func_sel;
   } pfs_pad_setup_t;

   // Drive toward one pad buffer
   typedef struct packed {
      logic out;
      logic oe_n;
      logic rx_en;
      logic pull_en;
      logic pull_up;
   } pfs_pad_drive_t;

endpackage : pfs_pkg

// ==== verif/pfs_far_model.sv ====
`timescale 1ns/100ps
module pfs_far_model (
   input  wire pfs_pkg::pfs_pad_drive_t [7:0] i_pad_drive,
   input  wire logic [7:0]                    i_ext_level,
   output logic [7:0]                         o_pad_level
);
   // Driver wins, then the pull, then whatever the board puts on the pad
   always_comb begin
      for (int p = 0; p < 8; p++) begin
         o_pad_level[p] = !i_pad_drive[p].oe_n ? i_pad_drive[p].out :
                          i_pad_drive[p].pull_en ? i_pad_drive[p].pull_up : i_ext_level[p];
      end
   end
endmodule : pfs_far_model

// ==== verif/pfs_monitor.sv ====
`timescale 1ns/100ps
module pfs_monitor #(parameter int MCU_STRAP_W = 4, parameter int MAIN_STRAP_W = 4) (
   input wire logic                            i_ref_clk,
   input wire logic                            i_rst,
   input wire logic                            i_mcu_poweron_reset_out,
   input wire logic                            i_main_poweron_reset_out,
   input wire logic                            i_reset_release,
   input wire logic [7:0]                      i_cfg_wr,
   input wire pfs_pkg::pfs_pad_setup_t         i_cfg_wdata,
   input wire pfs_pkg::pfs_pad_setup_t [7:0]   o_pad_setup_register,
   input wire logic [31:0]                     i_pin_select_register,
   input wire logic [63:0]                     i_func_oe,
   input wire logic [7:0]                      o_periph_in,
   input wire pfs_pkg::pfs_pad_drive_t [7:0]   o_pad_drive,
   input wire logic [MCU_STRAP_W-1:0]          o_mcu_boot_straps,
   input wire logic [MAIN_STRAP_W-1:0]         o_main_boot_straps
);
   logic [3:0] up_cnt_reg;
   logic [3:0] up_cnt_next;
   logic       up_ok;
   logic       sel_oe0;
   // Straps and pad muxing only settle some cycles after both resets rise
   assign up_cnt_next = !(i_mcu_poweron_reset_out && i_main_poweron_reset_out) ? 4'h0 :
                        (up_cnt_reg == 4'hF) ? up_cnt_reg : up_cnt_reg + 4'h1;
   assign up_ok = up_cnt_reg > 4'h8;
   assign sel_oe0 = i_func_oe[o_pad_setup_register[0].func_sel];
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) up_cnt_reg <= 4'h0;
      else up_cnt_reg <= up_cnt_next;
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // The synced default-mode load lands five edges after the pin fall and wins
   sequence s_cfg0;
      i_cfg_wr[0] && !($past(i_reset_release, 5) && !$past(i_reset_release, 4));
   endsequence
   sequence s_steady0;
      up_ok && !o_pad_setup_register[0].driver_off && $stable(i_func_oe)
      && $stable(o_pad_setup_register[0]);
   endsequence
   cfg_write_a: assert property (s_cfg0 |=> o_pad_setup_register[0] == $past(i_cfg_wdata))
      else $error("pad setup write lost");
   rst_dflt_a: assert property ($fell(i_rst) |-> o_pad_setup_register[0] == 7'h60)
      else $error("pad setup reset value wrong");
   drv_gate_a: assert property (o_pad_setup_register[0].driver_off |=> o_pad_drive[0].oe_n)
      else $error("driver on while disabled");
   oe_select_a: assert property (s_steady0 |=> o_pad_drive[0].oe_n == !$past(sel_oe0))
      else $error("selected function enable not on pad");
   rel_mode_a: assert property ($fell(i_reset_release) |-> ##[1:8]
      o_pad_setup_register[0].func_sel == pfs_pkg::MODE_REL_DFLT) else $error("no default mode");
   por_state_a: assert property ((!i_main_poweron_reset_out)[*6] |->
      o_pad_drive[0].oe_n && !o_pad_drive[0].pull_en) else $error("pad not in reset state");
   strap_hold_a: assert property (up_ok |-> $stable(o_main_boot_straps)
      && $stable(o_mcu_boot_straps)) else $error("boot straps moved");
   unrouted_a: assert property ((i_pin_select_register[3:0] >= 4'h8)[*2] |-> !o_periph_in[0])
      else $error("unrouted input not deselected value");
   rx_gate_a: assert property ((i_pin_select_register[3:0] < 4'h8 &&
      !o_pad_setup_register[i_pin_select_register[2:0]].receiver_on)[*3] |-> !o_periph_in[0])
      else $error("input passed with receiver off");
endmodule : pfs_monitor
bind pfs_pad_function_select pfs_monitor #(.MCU_STRAP_W(MCU_STRAP_W),
   .MAIN_STRAP_W(MAIN_STRAP_W)) i_pfs_monitor (.i_ref_clk, .i_rst, .i_mcu_poweron_reset_out,
   .i_main_poweron_reset_out, .i_reset_release, .i_cfg_wr, .i_cfg_wdata, .o_pad_setup_register,
   .i_pin_select_register, .i_func_oe, .o_periph_in, .o_pad_drive, .o_mcu_boot_straps,
   .o_main_boot_straps);

// ==== verif/pfs_pad_function_select_tb_top.sv ====
`timescale 1ns/100ps
module pfs_pad_function_select_tb_top;
   logic clk = 1'b0, rst = 1'b1, mcu_por = 1'b0, main_por = 1'b0, rel = 1'b1;
   logic [7:0] wr = 8'h00, ext = 8'h0A, pad, periph;
   logic [31:0] pin_sel = 32'hFFFFFFFF;
   logic [63:0] f_out = 64'h0, f_oe = 64'h0;
   logic [3:0] mcu_st, main_st;
   pfs_pkg::pfs_pad_setup_t wdata = 7'h00;
   pfs_pkg::pfs_pad_setup_t [7:0] setup;
   pfs_pkg::pfs_pad_drive_t [7:0] drive;
   logic [6:0] cfg_tbl [3] = '{7'h78, 7'h50, 7'h20};
   logic [3:0] exp_tbl [3] = '{4'hF, 4'h6, 4'h8};
   int error_cnt = 0;
   int comparisons = 0;
   pfs_pad_function_select #(
      .RST_STATES({{5{pfs_pkg::RST_FLOAT}}, pfs_pkg::RST_FLOAT_PU, pfs_pkg::RST_DRIVE1,
                   pfs_pkg::RST_FLOAT}),
      .DESEL_VALS(16'h0024)) i_pfs_pad_function_select (.i_ref_clk(clk), .i_rst(rst),
      .i_mcu_poweron_reset_out(mcu_por), .i_main_poweron_reset_out(main_por),
      .i_reset_release(rel),
      .i_cfg_wr(wr), .i_cfg_wdata(wdata), .o_pad_setup_register(setup),
      .i_pin_select_register(pin_sel), .i_func_out(f_out), .i_func_oe(f_oe),
      .o_periph_in(periph), .i_pad_in(pad), .o_pad_drive(drive),
      .o_mcu_boot_straps(mcu_st), .o_main_boot_straps(main_st));
   pfs_far_model i_pfs_far_model (.i_pad_drive(drive), .i_ext_level(ext), .o_pad_level(pad));
   initial forever #2.5 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_chk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_chk
   // Write lands on the second edge, pad drive follows one edge later
   task automatic write_pad(input int p, input logic [6:0] d);
      @(posedge clk);
      wr <= 8'h01 << p;
      wdata <= d;
      @(posedge clk);
      wr <= 8'h00;
   endtask : write_pad
   task automatic close_out;
      if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wait_chk(8);
      for (int p = 0; p < 8; p++) check(setup[p], 8'h60);
      check({drive[0].oe_n, drive[0].pull_en}, 8'h02);
      check({drive[1].oe_n, drive[1].out}, 8'h01);
      check({drive[2].oe_n, drive[2].pull_en, drive[2].pull_up}, 8'h07);
      @(posedge clk);
      mcu_por <= 1'b1;
      wait_chk(12);
      @(posedge clk);
      ext <= 8'h05;
      wait_chk(8);
      @(posedge clk);
      main_por <= 1'b1;
      wait_chk(12);
      check(mcu_st, 8'h0E);
      check(main_st, 8'h07);
      @(posedge clk);
      rel <= 1'b0;
      wait_chk(10);
      for (int p = 0; p < 8; p++) check(setup[p].func_sel, pfs_pkg::MODE_REL_DFLT);
      @(posedge clk);
      f_oe <= 64'h00000000000000FF;
      f_out <= 64'h000000000000005A;
      for (int f = 0; f < 8; f++) begin
         write_pad(0, {4'h8, f[2:0]});
         wait_chk(1);
         check({drive[0].out, drive[0].oe_n}, {6'h00, f_out[f], 1'b0});
      end
      for (int i = 0; i < 3; i++) begin
         write_pad(0, cfg_tbl[i]);
         wait_chk(1);
         check({drive[0].oe_n, drive[0].rx_en, drive[0].pull_en, drive[0].pull_up},
               exp_tbl[i]);
      end
      @(posedge clk);
      ext <= 8'h06;
      wait_chk(10);
      check(periph, 8'h06);
      @(posedge clk);
      pin_sel <= 32'hFFFFFFF1;
      wait_chk(10);
      check(periph, 8'h07);
      write_pad(1, 7'h20);
      wait_chk(10);
      check(periph, 8'h06);
      close_out();
   end
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      close_out();
   end
endmodule : pfs_pad_function_select_tb_top
